// >>> logic/datapath_regs.vh
`ifndef DATAPATH_REGS_VH
`define DATAPATH_REGS_VH
// register offsets on the slice's own register port
`define OFS_ACC0   5'h00
`define OFS_ACC1   5'h01
`define OFS_OPR0   5'h02
`define OFS_OPR1   5'h03
`define OFS_Q0     5'h04
`define OFS_Q1     5'h05
`define OFS_CTRL   5'h06
`define OFS_STAT   5'h07
`define OFS_CFGLO  5'h08
`define OFS_CFGHI  5'h09
`define OFS_CFGADR 5'h0A
`define OFS_MASK0  5'h0B
`define OFS_MASK1  5'h0C
`define OFS_POLY   5'h0D
`define OFS_MSB    5'h0E
`define OFS_ORMASK 5'h0F
`define OFS_OSEL0  5'h10
`define OFS_OSEL1  5'h11
`define OFS_OSEL2  5'h12
`define OFS_MODE   5'h13
`define OFS_STICKY 5'h14
`define OFS_QSTAT  5'h15
`define OFS_PINCFG 5'h16
`define OFS_PININ  5'h17
// reset values
`define RST_BYTE   8'h00
`define RST_MODE   8'h0C
`define RST_CFG    16'h0000
`define RST_MASK   8'hFF
`define RST_MSB    3'h7
`define RST_OSEL   24'h00_0000
// configuration word fields
`define F_FUNC     2:0
`define F_SRCA     3
`define F_SRCB     5:4
`define F_SHIFT    7:6
`define F_DWE      8
`define F_DSEL     9
`define F_DSRC     11:10
`define F_PUSH     12
`define F_CSEL     13
`define F_CRC      14
`define F_ORM      15
// mode register fields
`define M_DIR0     0
`define M_DIR1     1
`define M_DPEN     2
`define M_SCEN     3
`define M_CHAIN    4
`define M_CMPSEL   5
// alu function codes
`define FN_PASS    3'h0
`define FN_INC     3'h1
`define FN_DEC     3'h2
`define FN_ADD     3'h3
`define FN_SUB     3'h4
`define FN_AND     3'h5
`define FN_OR      3'h6
`define FN_XOR     3'h7
`endif

// >>> logic/byte_datapath.v
// How it works
// [RULE1] six bus-visible working registers: two accumulators, two operand regs, two queues
// [RULE2] accumulators are alu operand, alu destination and compare operand
// [RULE3] operand registers only feed the alu and compares; data source 3 also loads operand b straight into an accumulator
// [RULE4] queues load operand regs/accumulators or capture accumulator or alu result
// [RULE5] two four-entry queues, each independently input or output direction
// [RULE6] queue empty and full conditions selectable onto slice outputs
// [RULE7] eight 16-bit config words, 3-bit routed address picks one per cycle
// [RULE8] alu does inc, dec, add, sub, and, or, xor, pass
// [RULE9] shift left, shift right, nibble swap and or-mask after the alu
// [RULE10] two masked compares with selectable operand pairings
// [RULE11] zero, all-ones, overflow detect; selected conditions drive routing outputs
// [RULE12] carry, shift and compare chain to and from neighbour slices
// [RULE13] programmable msb position for arithmetic, shift and output masking
// [RULE14] one crc or pseudo random sequence step per cycle, programmable polynomial
// [RULE15] carry and shift out registered, selectable as later inputs
// [RULE16] six routing inputs and six selectable routing outputs
// [RULE17] bus-writable control register drives routing
// [RULE18] read-only status register shows internal conditions
// [RULE19] status bits may latch pulses until a status read clears them
// [RULE20] datapath and status/control each have their own enable; the status/control one gates only the status register
// [RULE21] port has sixteen data routes and four drive controls
// [RULE22] pin output optionally one extra stage, pin input synchronised twice
// [RULE23] queues report empty/full; full write or empty read leaves contents
`timescale 1ns/1ps
`default_nettype none
`include "datapath_regs.vh"

// byte queue with valid/ready on both sides
module byte_queue #(
    parameter W  = 8,
    parameter D  = 8,
    parameter AW = 3
) (
    // clock and reset
    input  wire         clock,
    input  wire         resetn,
    // fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data,
    // status
    output wire         full,
    output wire         empty
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire         wr = in_valid & in_ready;
    wire         rd = out_valid & out_ready;

    // full write and empty read are refused by the handshake
    assign full      = (cnt_r == D[AW:0]); // RULE23
    assign empty     = (cnt_r == {(AW+1){1'b0}}); // RULE23
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rp_r];

    // pointers wrap at the depth, not at the power of two
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (wr)
                wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            if (rd)
                rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            if (wr & ~rd)
                cnt_r <= cnt_r + 1'b1;
            else if (rd & ~wr)
                cnt_r <= cnt_r - 1'b1;
        end
    end

    // storage needs no reset
    always @(posedge clock) begin
        if (wr)
            mem[wp_r] <= in_data;
    end
endmodule // byte_queue

module byte_datapath #(
    parameter QDEPTH = 4,
    parameter QAW    = 2
) (
    // clock and reset
    input  wire       clock,
    input  wire       resetn,
    // register port
    input  wire       bus_req,
    input  wire       bus_we,
    input  wire [4:0] bus_addr,
    input  wire [7:0] bus_wdata,
    output reg        bus_ack_r,
    output reg  [7:0] bus_rdata_r,
    // routing matrix
    input  wire [5:0] route_in,
    output reg  [5:0] route_out_r,
    output reg  [7:0] ctrl_out_r,
    // neighbour chaining
    input  wire       chain_carry_in,
    input  wire       chain_shift_in,
    input  wire       chain_cmp_in,
    output reg        chain_carry_out_r,
    output reg        chain_shift_out_r,
    output reg        chain_cmp_out_r,
    // io port
    input  wire [7:0] pin_in,
    output reg  [7:0] pin_out_r,
    output reg  [7:0] pin_oe_r
);
    reg  [7:0]  acc0_r, acc1_r, opr0_r, opr1_r;
    reg  [15:0] cfg_ram [0:7];
    reg  [7:0]  cfglo_r, mask0_r, mask1_r, poly_r, ormask_r;
    reg  [7:0]  mode_r, sticky_r, stat_r, pincfg_r, pin_s1_r, pin_s2_r, pin_pipe_r;
    reg  [2:0]  cfgadr_r, msb_r;
    reg  [23:0] osel_r;
    reg         carry_r, shift_r;
    reg  [8:0]  r9;
    reg  [7:0]  b, sh, res, acc_val, rd_mux;
    reg         sout;
    integer     k;

    // width mask from the msb position
    function [7:0] width_mask;
        input [2:0] m;
        width_mask = 8'hFF >> (3'd7 - m);
    endfunction

    wire       wr  = bus_req & bus_we;
    wire       rdq = bus_req & ~bus_we;
    wire       dir0 = mode_r[`M_DIR0];
    wire       dir1 = mode_r[`M_DIR1];
    wire       dp_en = mode_r[`M_DPEN];
    wire       sc_en = mode_r[`M_SCEN];
    wire       chain = mode_r[`M_CHAIN];
    wire [15:0] cw = cfg_ram[route_in[2:0]]; // RULE7 RULE16
    wire [7:0] wm = width_mask(msb_r); // RULE13
    wire [7:0] a  = cw[`F_SRCA] ? acc1_r : acc0_r; // RULE2
    wire       cin = cw[`F_CSEL] ? carry_r : chain_carry_in; // RULE15 RULE12
    wire       sin = cw[`F_CSEL] ? shift_r : (chain ? chain_shift_in : route_in[3]); // RULE15

    // queue handshakes
    wire       q0_iv, q0_ir, q0_ov, q0_or, q0_full, q0_empty;
    wire       q1_iv, q1_ir, q1_ov, q1_or, q1_full, q1_empty;
    wire [7:0] q0_head, q1_head;

    // operand b may be either accumulator or either operand register
    always @* begin
        case (cw[`F_SRCB])
            2'd0:    b = acc0_r;
            2'd1:    b = acc1_r;
            2'd2:    b = opr0_r; // RULE3
            default: b = opr1_r; // RULE3
        endcase
    end

    // alu, nine bits wide so the carry falls out for free
    always @* begin
        case (cw[`F_FUNC])
            `FN_PASS: r9 = {1'b0, a};
            `FN_INC:  r9 = {1'b0, a} + 9'h001;
            `FN_DEC:  r9 = {1'b0, a} - 9'h001;
            `FN_ADD:  r9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            `FN_SUB:  r9 = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
            `FN_AND:  r9 = {1'b0, a & b};
            `FN_OR:   r9 = {1'b0, a | b};
            default:  r9 = {1'b0, a ^ b};
        endcase
    end // RULE8

    // carry taken at msb+1 so narrow counters chain correctly
    wire [7:0] alu  = r9[7:0] & wm;
    wire       cout = r9[{1'b0, msb_r} + 4'd1]; // RULE13
    wire       fb   = a[msb_r] ^ sin;
    wire [7:0] crcv = (({a[6:0], 1'b0}) ^ (fb ? poly_r : 8'h00)) & wm; // RULE14

    // post-alu stage, then crc override and or-mask
    always @* begin
        sout = 1'b0;
        case (cw[`F_SHIFT])
            2'd0: sh = alu;
            2'd1: begin
                sh   = {alu[6:0], sin} & wm;
                sout = alu[msb_r];
            end
            2'd2: begin
                sh   = (alu >> 1) | ({7'h00, sin} << msb_r);
                sout = alu[0];
            end
            default: sh = {alu[3:0], alu[7:4]};
        endcase // RULE9
        if (cw[`F_CRC]) begin
            sh   = crcv;
            sout = fb;
        end
        res = cw[`F_ORM] ? (sh | ormask_r) : sh; // RULE9
    end

    // conditions
    wire arith = (cw[`F_FUNC] == `FN_ADD) | (cw[`F_FUNC] == `FN_SUB);
    wire bm    = (cw[`F_FUNC] == `FN_SUB) ? ~b[msb_r] : b[msb_r];
    wire ovf   = arith & (a[msb_r] == bm) & (res[msb_r] != a[msb_r]); // RULE11
    wire zero  = ((res & wm) == 8'h00); // RULE11
    wire ones  = ((res & wm) == wm); // RULE11
    wire [7:0] c0b = mode_r[`M_CMPSEL] ? acc1_r : opr0_r;
    wire c0_eq = ((acc0_r & mask0_r) == (c0b & mask0_r)); // RULE10
    wire c0_lt = ((acc0_r & mask0_r) <  (c0b & mask0_r)); // RULE10
    wire c1_eq = ((acc1_r & mask1_r) == (opr1_r & mask1_r)); // RULE10
    wire c1_lt = ((acc1_r & mask1_r) <  (opr1_r & mask1_r)); // RULE10
    wire c_ch  = c0_eq & (chain ? chain_cmp_in : 1'b1); // RULE12
    wire [15:0] cond = {1'b0, sout, c_ch, q1_full, q1_empty, q0_full, q0_empty,
                        carry_r, ovf, ones, zero, c1_lt, c1_eq, c0_lt, c0_eq, 1'b0}; // RULE6

    // queue traffic; a full output queue stalls the whole step when the word pushes
    wire ld0   = (cw[`F_DWE] & (cw[`F_DSRC] == 2'd1)) | route_in[4];
    wire ld1   = (cw[`F_DWE] & (cw[`F_DSRC] == 2'd2)) | route_in[5];
    wire need0 = ld0 & ~dir0;
    wire need1 = ld1 & ~dir1;
    wire stall = (need0 & q0_empty) | (need1 & q1_empty) |
                 (cw[`F_PUSH] & ((dir0 & q0_full) | (dir1 & q1_full)));
    wire go    = dp_en & ~stall; // RULE20
    wire bw_q0 = wr & (bus_addr == `OFS_Q0);
    wire bw_q1 = wr & (bus_addr == `OFS_Q1);
    wire br_q0 = rdq & (bus_addr == `OFS_Q0);
    wire br_q1 = rdq & (bus_addr == `OFS_Q1);
    assign q0_iv = dir0 ? (go & cw[`F_PUSH]) : bw_q0; // RULE5 RULE4
    assign q1_iv = dir1 ? (go & cw[`F_PUSH]) : bw_q1; // RULE5 RULE4
    assign q0_or = dir0 ? br_q0 : (go & need0);
    assign q1_or = dir1 ? br_q1 : (go & need1);

    byte_queue #(.W(8), .D(QDEPTH), .AW(QAW)) u_q0 (
        .clock(clock), .resetn(resetn),
        .in_valid(q0_iv), .in_ready(q0_ir), .in_data(dir0 ? res : bus_wdata),
        .out_valid(q0_ov), .out_ready(q0_or), .out_data(q0_head),
        .full(q0_full), .empty(q0_empty)
    );
    byte_queue #(.W(8), .D(QDEPTH), .AW(QAW)) u_q1 (
        .clock(clock), .resetn(resetn),
        .in_valid(q1_iv), .in_ready(q1_ir), .in_data(dir1 ? acc1_r : bus_wdata),
        .out_valid(q1_ov), .out_ready(q1_or), .out_data(q1_head),
        .full(q1_full), .empty(q1_empty)
    );

    // accumulator load source
    always @* begin
        case (cw[`F_DSRC])
            2'd0:    acc_val = res;
            2'd1:    acc_val = q0_head; // RULE4
            2'd2:    acc_val = q1_head; // RULE4
            default: acc_val = b;
        endcase
    end

    // working registers; a bus write wins over a datapath write
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            acc0_r  <= `RST_BYTE;
            acc1_r  <= `RST_BYTE;
            opr0_r  <= `RST_BYTE;
            opr1_r  <= `RST_BYTE;
            carry_r <= 1'b0;
            shift_r <= 1'b0;
        end else begin
            if (go) begin
                carry_r <= cout; // RULE15
                shift_r <= sout; // RULE15
                if (cw[`F_DWE] & ~cw[`F_DSEL])
                    acc0_r <= acc_val; // RULE2
                if (cw[`F_DWE] & cw[`F_DSEL])
                    acc1_r <= acc_val; // RULE2
                if (route_in[4] & ~dir0)
                    opr0_r <= q0_head; // RULE4
                if (route_in[5] & ~dir1)
                    opr1_r <= q1_head; // RULE4
            end
            if (wr & (bus_addr == `OFS_ACC0)) acc0_r <= bus_wdata; // RULE1
            if (wr & (bus_addr == `OFS_ACC1)) acc1_r <= bus_wdata; // RULE1
            if (wr & (bus_addr == `OFS_OPR0)) opr0_r <= bus_wdata; // RULE1
            if (wr & (bus_addr == `OFS_OPR1)) opr1_r <= bus_wdata; // RULE1
        end
    end

    // configuration and mode registers
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (k = 0; k < 8; k = k + 1)
                cfg_ram[k] <= `RST_CFG;
            cfglo_r  <= `RST_BYTE;
            cfgadr_r <= 3'h0;
            mask0_r  <= `RST_MASK;
            mask1_r  <= `RST_MASK;
            poly_r   <= `RST_BYTE;
            msb_r    <= `RST_MSB;
            ormask_r <= `RST_BYTE;
            osel_r   <= `RST_OSEL;
            mode_r   <= `RST_MODE;
            sticky_r <= `RST_BYTE;
            pincfg_r <= `RST_BYTE;
            ctrl_out_r <= `RST_BYTE;
        end else if (wr) begin
            case (bus_addr)
                `OFS_CFGLO:  cfglo_r <= bus_wdata;
                `OFS_CFGHI:  cfg_ram[cfgadr_r] <= {bus_wdata, cfglo_r}; // RULE7
                `OFS_CFGADR: cfgadr_r <= bus_wdata[2:0];
                `OFS_MASK0:  mask0_r <= bus_wdata;
                `OFS_MASK1:  mask1_r <= bus_wdata;
                `OFS_POLY:   poly_r <= bus_wdata;
                `OFS_MSB:    msb_r <= bus_wdata[2:0];
                `OFS_ORMASK: ormask_r <= bus_wdata;
                `OFS_OSEL0:  osel_r[7:0] <= bus_wdata;
                `OFS_OSEL1:  osel_r[15:8] <= bus_wdata;
                `OFS_OSEL2:  osel_r[23:16] <= bus_wdata;
                `OFS_MODE:   mode_r <= bus_wdata;
                `OFS_STICKY: sticky_r <= bus_wdata;
                `OFS_PINCFG: pincfg_r <= bus_wdata;
                `OFS_CTRL:   ctrl_out_r <= bus_wdata; // RULE17
                default:     cfglo_r <= cfglo_r;
            endcase
        end
    end

    // status: sticky bits hold until read, a new event beats the clear
    wire stat_rd = rdq & (bus_addr == `OFS_STAT);
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            stat_r <= `RST_BYTE;
        else if (sc_en) // RULE20
            stat_r <= cond[8:1] | (sticky_r & stat_r & {8{~stat_rd}}); // RULE18 RULE19
    end

    // routing outputs, each picks one condition
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_route
            always @(posedge clock or negedge resetn) begin
                if (!resetn)
                    route_out_r[g] <= 1'b0;
                else
                    route_out_r[g] <= cond[osel_r[4*g+3:4*g]]; // RULE11 RULE16
            end
        end
        for (g = 0; g < 4; g = g + 1) begin : g_oe
            always @(posedge clock or negedge resetn) begin
                if (!resetn)
                    pin_oe_r[2*g+1:2*g] <= 2'b00;
                else
                    pin_oe_r[2*g+1:2*g] <= {2{pincfg_r[4+g]}}; // RULE21
            end
        end
    endgenerate

    // chaining outputs and pins; first sync stage feeds only the second
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chain_carry_out_r <= 1'b0;
            chain_shift_out_r <= 1'b0;
            chain_cmp_out_r   <= 1'b0;
            pin_s1_r   <= `RST_BYTE;
            pin_s2_r   <= `RST_BYTE;
            pin_pipe_r <= `RST_BYTE;
            pin_out_r  <= `RST_BYTE;
        end else begin
            chain_carry_out_r <= cout; // RULE12
            chain_shift_out_r <= sout; // RULE12
            chain_cmp_out_r   <= c_ch; // RULE12
            pin_s1_r   <= pin_in; // RULE22
            pin_s2_r   <= pin_s1_r; // RULE22
            pin_pipe_r <= ctrl_out_r;
            pin_out_r  <= pincfg_r[0] ? pin_pipe_r : ctrl_out_r; // RULE22 RULE21
        end
    end

    // read data; empty or wrong-direction queue reads give zero
    always @* begin
        case (bus_addr)
            `OFS_ACC0:   rd_mux = acc0_r;
            `OFS_ACC1:   rd_mux = acc1_r;
            `OFS_OPR0:   rd_mux = opr0_r;
            `OFS_OPR1:   rd_mux = opr1_r;
            `OFS_Q0:     rd_mux = (dir0 & q0_ov) ? q0_head : 8'h00; // RULE23
            `OFS_Q1:     rd_mux = (dir1 & q1_ov) ? q1_head : 8'h00; // RULE23
            `OFS_CTRL:   rd_mux = ctrl_out_r;
            `OFS_STAT:   rd_mux = stat_r; // RULE18
            `OFS_CFGADR: rd_mux = {5'h00, cfgadr_r};
            `OFS_MASK0:  rd_mux = mask0_r;
            `OFS_MASK1:  rd_mux = mask1_r;
            `OFS_POLY:   rd_mux = poly_r;
            `OFS_MSB:    rd_mux = {5'h00, msb_r};
            `OFS_ORMASK: rd_mux = ormask_r;
            `OFS_OSEL0:  rd_mux = osel_r[7:0];
            `OFS_OSEL1:  rd_mux = osel_r[15:8];
            `OFS_OSEL2:  rd_mux = osel_r[23:16];
            `OFS_MODE:   rd_mux = mode_r;
            `OFS_STICKY: rd_mux = sticky_r;
            `OFS_QSTAT:  rd_mux = {4'h0, q1_full, q1_empty, q0_full, q0_empty}; // RULE23
            `OFS_PINCFG: rd_mux = pincfg_r;
            `OFS_PININ:  rd_mux = pin_s2_r;
            default:     rd_mux = 8'h00;
        endcase
    end

    // one-cycle answer to every request
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_ack_r   <= 1'b0;
            bus_rdata_r <= 8'h00;
        end else begin
            bus_ack_r   <= bus_req;
            bus_rdata_r <= rdq ? rd_mux : 8'h00;
        end
    end
endmodule // byte_datapath
`default_nettype wire

// >>> testbench/byte_datapath_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "datapath_regs.vh"
// watches the register port, control outputs and pin stages
module byte_datapath_sva (
    // clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // register port
    input wire logic       bus_req,
    input wire logic       bus_we,
    input wire logic [4:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_ack_r,
    input wire logic [7:0] bus_rdata_r,
    // control and pins
    input wire logic [7:0] ctrl_out_r,
    input wire logic [7:0] pin_out_r,
    input wire logic [7:0] pin_oe_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [7:0] pcfg_r;
    wire        wr_ctrl = bus_req && bus_we && (bus_addr == `OFS_CTRL);
    wire        wr_pcfg = bus_req && bus_we && (bus_addr == `OFS_PINCFG);
    wire        rd_hole = bus_req && !bus_we && (bus_addr > `OFS_PININ);
    wire  [7:0] oe_exp  = {{2{pcfg_r[7]}}, {2{pcfg_r[6]}}, {2{pcfg_r[5]}}, {2{pcfg_r[4]}}};
    // shadow of pin config, the only way to know which delay applies
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            pcfg_r <= 8'h00;
        else if (wr_pcfg)
            pcfg_r <= bus_wdata;
    end
    property p_ack_one; bus_req |=> bus_ack_r; endproperty
    a_ack_one: assert property (p_ack_one) else $error("no ack after request");
    property p_ack_only; !bus_req |=> !bus_ack_r; endproperty
    a_ack_only: assert property (p_ack_only) else $error("ack without request");
    property p_rdata_idle; !bus_req |=> bus_rdata_r == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_hole; rd_hole |=> bus_ack_r && bus_rdata_r == 8'h00; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_ctrl_write; wr_ctrl |=> ctrl_out_r == $past(bus_wdata); endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control not written");
    property p_ctrl_hold; !wr_ctrl |=> $stable(ctrl_out_r); endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved");
    property p_pin_one;
        !pcfg_r[0] && !$past(pcfg_r[0]) |-> pin_out_r == $past(ctrl_out_r);
    endproperty
    a_pin_one: assert property (p_pin_one) else $error("pin output not one stage");
    property p_pin_two;
        pcfg_r[0] && $past(pcfg_r[0]) && $past(pcfg_r[0], 2) |-> pin_out_r == $past(ctrl_out_r, 2);
    endproperty
    a_pin_two: assert property (p_pin_two) else $error("pin output not two stages");
    property p_pin_oe; pin_oe_r == $past(oe_exp); endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("output enable pairs wrong");
    c_ctrl: cover property (wr_ctrl);
    c_pcfg: cover property (pcfg_r[0] ##3 pcfg_r[0]);
    c_read: cover property (bus_req && !bus_we ##1 bus_ack_r);
endmodule // byte_datapath_sva
bind byte_datapath byte_datapath_sva u_sva (.clock(clock), .resetn(resetn), .bus_req(bus_req),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack_r(bus_ack_r),
    .bus_rdata_r(bus_rdata_r), .ctrl_out_r(ctrl_out_r), .pin_out_r(pin_out_r),
    .pin_oe_r(pin_oe_r));
`default_nettype wire

// >>> testbench/neighbour_slice.sv
`timescale 1ns/1ps
`default_nettype none
// neighbouring slice: presents registered chain lines only
module neighbour_slice (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // state the bench loads into the neighbour
    input  wire logic [2:0] load_bits,
    // chain lines toward the slice
    output var  logic       chain_carry,
    output var  logic       chain_shift,
    output var  logic       chain_cmp
);
    // a real neighbour changes its chain outputs only on the shared clock
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            {chain_carry, chain_shift, chain_cmp} <= 3'h0;
        else
            {chain_carry, chain_shift, chain_cmp} <= load_bits;
    end
endmodule // neighbour_slice
`default_nettype wire

// >>> testbench/tb_programmable_byte_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "datapath_regs.vh"
module tb_programmable_byte_datapath;
    logic clock, resetn, bus_req, bus_we, bus_ack_r, c_in, s_in, k_in;
    logic [4:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata_r, ctrl_out_r, pin_in, pin_out_r, pin_oe_r, a, b, d, q;
    logic [5:0] route_in, route_out_r;
    logic [2:0] nb_bits, f;
    logic [1:0] s;
    logic [7:0] qv [0:4];
    int fails, checks_done, i;
    // device under test and its chain neighbour
    byte_datapath DUT (.clock(clock), .resetn(resetn), .bus_req(bus_req), .bus_we(bus_we),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack_r(bus_ack_r),
        .bus_rdata_r(bus_rdata_r), .route_in(route_in), .route_out_r(route_out_r),
        .ctrl_out_r(ctrl_out_r), .chain_carry_in(c_in), .chain_shift_in(s_in),
        .chain_cmp_in(k_in), .chain_carry_out_r(), .chain_shift_out_r(),
        .chain_cmp_out_r(), .pin_in(pin_in), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r));
    neighbour_slice u_nb (.clock(clock), .resetn(resetn), .load_bits(nb_bits),
        .chain_carry(c_in), .chain_shift(s_in), .chain_cmp(k_in));
    // 200 MHz clock
    always #2.5 clock = ~clock;
    // expected alu result, carry in comes from the neighbour
    function automatic logic [7:0] alu_exp(logic [2:0] fn, logic [7:0] x, logic [7:0] y, logic ci);
        case (fn)
            3'h1: return x + 8'h01;
            3'h2: return x - 8'h01;
            3'h3: return x + y + ci;
            3'h4: return x + ~y + ci;
            3'h5: return x & y;
            3'h6: return x | y;
            3'h7: return x ^ y;
            default: return x;
        endcase
    endfunction
    // expected shifter output, shift-in bit zero
    function automatic logic [7:0] shf_exp(logic [1:0] sh, logic [7:0] v);
        case (sh)
            2'h1: return {v[6:0], 1'b0};
            2'h2: return {1'b0, v[7:1]};
            2'h3: return {v[3:0], v[7:4]};
            default: return v;
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one access: request held for one edge, answer taken 1 ns after that same edge
    task automatic bus(input logic we, input logic [4:0] ad, input logic [7:0] wd);
        @(posedge clock);
        bus_req   <= 1'b1;
        bus_we    <= we;
        bus_addr  <= ad;
        bus_wdata <= wd;
        @(posedge clock);
        bus_req <= 1'b0;
        #1;
        check({7'h00, bus_ack_r}, 8'h01);
        q = bus_rdata_r;
    endtask
    task automatic wr(input logic [4:0] ad, input logic [7:0] wd);
        bus(1'b1, ad, wd);
    endtask
    task automatic rdchk(input logic [4:0] ad, input logic [7:0] exp);
        bus(1'b0, ad, 8'h00);
        check(q, exp);
    endtask
    task automatic cfg(input logic [2:0] ad, input logic [15:0] w);
        wr(`OFS_CFGADR, {5'h00, ad});
        wr(`OFS_CFGLO, w[7:0]);
        wr(`OFS_CFGHI, w[15:8]);
    endtask
    // one datapath step with the given routing inputs
    task automatic step(input logic [5:0] r);
        @(posedge clock);
        route_in <= r;
        @(posedge clock);
        route_in <= 6'h00;
    endtask
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clock);
        fails = fails + 1;
        give_verdict;
    end
    initial begin
        {clock, resetn, bus_req, bus_we, bus_addr, bus_wdata, route_in, pin_in, nb_bits} = '0;
        fails = 0;
        checks_done = 0;
        void'($urandom(88));
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        rdchk(`OFS_MODE, `RST_MODE);
        rdchk(`OFS_MASK0, `RST_MASK);
        rdchk(`OFS_MSB, {5'h00, `RST_MSB});
        rdchk(`OFS_CTRL, `RST_BYTE);
        $display("test reset values done");
        for (i = 0; i < 12; i++) begin
            d = $urandom;
            wr(5'(i % 4), d);
            rdchk(5'(i % 4), d);
        end
        wr(5'h1F, 8'hA5);
        rdchk(5'h1F, 8'h00);
        $display("test working registers done");
        for (i = 0; i < 11; i++) begin
            a = (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : 8'($urandom);
            b = $urandom;
            nb_bits <= 3'($urandom);
            f = (i < 8) ? 3'(i) : 3'h0;
            s = (i < 8) ? 2'h0 : 2'(i - 7);
            cfg(3'h1, {7'h00, 1'b1, s, 2'b10, 1'b0, f});
            wr(`OFS_ACC0, a);
            wr(`OFS_OPR0, b);
            step(6'h01);
            rdchk(`OFS_ACC0, shf_exp(s, alu_exp(f, a, b, nb_bits[2])));
        end
        $display("test alu and shifter done");
        for (i = 0; i < 5; i++) begin
            qv[i] = $urandom;
            wr(`OFS_Q0, qv[i]);
        end
        rdchk(`OFS_Q0, 8'h00);
        wr(`OFS_OSEL0, 8'h9A);
        rdchk(`OFS_OSEL0, 8'h9A);
        check({6'h00, route_out_r[1:0]}, 8'h01);
        for (i = 0; i < 5; i++) begin
            step(6'h10);
            rdchk(`OFS_OPR0, qv[(i < 4) ? i : 3]);
        end
        check({6'h00, route_out_r[1:0]}, 8'h02);
        $display("test input queue done");
        wr(`OFS_MODE, 8'h0D);
        cfg(3'h2, 16'h1000);
        for (i = 0; i < 5; i++) begin
            qv[i] = $urandom;
            wr(`OFS_ACC0, qv[i]);
            step(6'h02);
        end
        for (i = 0; i < 5; i++)
            rdchk(`OFS_Q0, (i < 4) ? qv[i] : 8'h00);
        wr(`OFS_MODE, `RST_MODE);
        $display("test output queue done");
        for (i = 0; i < 8; i++) begin
            pin_in <= 8'($urandom);
            d = $urandom;
            wr(`OFS_CTRL, d);
            check(ctrl_out_r, d);
            wr(`OFS_PINCFG, 8'($urandom));
            rdchk(`OFS_PININ, pin_in);
            repeat (3) @(posedge clock);
        end
        $display("test control and pins done");
        give_verdict;
    end
endmodule // tb_programmable_byte_datapath
`default_nettype wire
